// file: hdl/mbp_top.sv
// mode dependent pin configuration for the multiplexed external bus ports
//
// The register addresses and register access over APB were left to the implementer.
`timescale 1ns/100ps
module mbp_top
(
  // clock and reset
  input wire logic CLOCK,
  input wire logic RST_N,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // mode select pins, read at reset release
  input wire logic MODE_SELECT_PIN_C,
  input wire logic MODE_SELECT_PIN_B,
  input wire logic MODE_SELECT_PIN_A,
  // core bus signals to be placed on the pins
  input wire logic [15:0] CORE_ADDR,
  input wire logic [15:0] CORE_WDATA,
  input wire logic CORE_BUS_WRITE,
  input wire logic CORE_ACCESS_EXT,
  input wire logic CORE_MAPPED_INTERNAL,
  input wire logic CORE_HIGH_BYTE,
  input wire logic CORE_DATA_PHASE,
  input wire logic LOW_BYTE_STROBE_IN,
  input wire logic PIPE_STATUS_HIGH,
  input wire logic PIPE_STATUS_LOW,
  input wire logic NO_ACCESS_INDICATOR,
  input wire logic E_CLOCK_IN,
  input wire logic E_CLOCK_STRETCHED,
  // general purpose port values and directions
  input wire logic [7:0] GPIO_A_OUT,
  input wire logic [7:0] GPIO_A_DIR,
  input wire logic [7:0] GPIO_B_OUT,
  input wire logic [7:0] GPIO_B_DIR,
  input wire logic [7:0] GPIO_E_OUT,
  input wire logic [7:0] GPIO_E_DIR,
  // pins
  input wire logic [7:0] PORT_A_IN,
  output logic [7:0] PORT_A_OUT,
  output logic [7:0] PORT_A_OE,
  output logic [7:0] PORT_A_PULL,
  input wire logic [7:0] PORT_B_IN,
  output logic [7:0] PORT_B_OUT,
  output logic [7:0] PORT_B_OE,
  output logic [7:0] PORT_B_PULL,
  input wire logic [7:0] PORT_E_IN,
  output logic [7:0] PORT_E_OUT,
  output logic [7:0] PORT_E_OE,
  output logic [7:0] PORT_E_PULL,
  // status
  output logic [2:0] MODE,
  output logic BUS_EXPANDED
);
  logic wr_mode;
  logic wr_pea;
  logic wr_bic;
  logic rd_any;
  logic [2:0] mode_pins_s;
  logic [7:0] port_a_s;
  logic [7:0] port_b_s;
  logic [7:0] port_e_s;
  logic mode_taken;
  mbp_pkg::mbp_mode_t mode;
  logic mode_written;
  logic pea_written;
  logic internal_visibility_enable;
  logic no_access_enable;
  logic pipe_status_output_enable;
  logic e_clock_disable;
  logic low_strobe_enable;
  logic read_write_pin_enable;
  logic e_clock_stretch_enable;
  logic single_chip;
  logic emulation;
  logic wide;
  logic narrow;
  logic normal_narrow;
  logic next_sel_no_access_indicator;
  logic next_sel_pipe;
  logic next_sel_e_clock_output;
  logic next_sel_low_byte_strobe;
  logic next_sel_rw;
  logic next_bus_ab;
  logic sel_no_access_indicator;
  logic sel_pipe;
  logic sel_e_clock_output;
  logic sel_low_byte_strobe;
  logic sel_rw;
  logic bus_ab;
  logic [7:0] pea_value;
  logic [2:0] next_mode_bits;
  logic [15:0] bus_word;
  logic [7:0] next_a_out;
  logic [7:0] next_b_out;
  logic [7:0] next_e_out;
  logic [7:0] next_e_oe;
  logic [7:0] next_e_pull;
  logic e_clock_level;
  logic e_clock_in_s;
  logic e_clock_stretched_s;
  logic [1:0] settle;

  mbp_apb u_apb
  (
    .psel(PSEL),
    .penable(PENABLE),
    .pwrite(PWRITE),
    .paddr(PADDR),
    .pready(PREADY),
    .pslverr(PSLVERR),
    .wr_mode(wr_mode),
    .wr_pea(wr_pea),
    .wr_bic(wr_bic),
    .rd_any(rd_any)
  );

  // pins and the free-running e clocks come from outside the clock domain
  mbp_sync #(.WIDTH(29)) u_sync
  (
    .clk(CLOCK),
    .rst_n(RST_N),
    .d({MODE_SELECT_PIN_C, MODE_SELECT_PIN_B, MODE_SELECT_PIN_A, PORT_A_IN, PORT_B_IN,
      PORT_E_IN, E_CLOCK_IN, E_CLOCK_STRETCHED}),
    .q({mode_pins_s, port_a_s, port_b_s, port_e_s, e_clock_in_s, e_clock_stretched_s})
  );

  // mode decodes
  assign single_chip = (mode == mbp_pkg::MBP_NORM_SINGLE) || (mode == mbp_pkg::MBP_SPECIAL_SINGLE);
  assign emulation = (mode == mbp_pkg::MBP_EMU_NARROW) || (mode == mbp_pkg::MBP_EMU_WIDE);
  assign wide = (mode == mbp_pkg::MBP_NORM_WIDE) || (mode == mbp_pkg::MBP_EMU_WIDE)
    || (mode == mbp_pkg::MBP_SPECIAL_TEST);
  assign narrow = (mode == mbp_pkg::MBP_NORM_NARROW) || (mode == mbp_pkg::MBP_EMU_NARROW);
  assign normal_narrow = (mode == mbp_pkg::MBP_NORM_NARROW);
  assign next_mode_bits = PWDATA[mbp_pkg::MBP_MODE_LSB+2:mbp_pkg::MBP_MODE_LSB];

  // mode latched once, after the pins have settled through the synchroniser
  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      settle <= 2'h0;
      mode_taken <= 1'b0;
      mode <= mbp_pkg::MBP_NORM_SINGLE;
      mode_written <= 1'b0;
    end
    else if (!mode_taken)
    begin
      // the synchroniser is cleared by reset, so wait until it holds the released pins
      if (settle == 2'h2)
      begin
        mode_taken <= 1'b1;
        mode <= mbp_pkg::mbp_mode_t'(mode_pins_s);
      end
      else
      begin
        settle <= settle + 2'h1;
      end
    end
    else if (wr_mode && (mode == mbp_pkg::MBP_NORM_SINGLE) && !mode_written)
    begin
      // one write only, and only to an expanded normal mode
      mode_written <= 1'b1;
      if ((next_mode_bits == 3'h5) || (next_mode_bits == 3'h7))
      begin
        mode <= mbp_pkg::mbp_mode_t'(next_mode_bits);
      end
    end
  end

  // visibility bit; normal narrow cannot split internal cycles so it stays off
  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      internal_visibility_enable <= 1'b0;
    end
    else if (wr_mode && (mode == mbp_pkg::MBP_NORM_SINGLE) && !mode_written)
    begin
      internal_visibility_enable <= PWDATA[mbp_pkg::MBP_MODE_INTERNAL_VISIBILITY_ENABLE]
        && !(next_mode_bits == 3'h5);
    end
    else if (normal_narrow || single_chip)
    begin
      internal_visibility_enable <= 1'b0;
    end
  end

  // port e assignment register; narrow normal mode allows one write, emulation none
  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      no_access_enable <= 1'b0;
      pipe_status_output_enable <= 1'b0;
      e_clock_disable <= 1'b0;
      low_strobe_enable <= 1'b0;
      read_write_pin_enable <= 1'b0;
      pea_written <= 1'b0;
    end
    else if (wr_pea && mode_taken && !emulation && !(normal_narrow && pea_written))
    begin
      pea_written <= 1'b1;
      no_access_enable <= PWDATA[mbp_pkg::MBP_PEA_NO_ACCESS_INDICATOR];
      pipe_status_output_enable <= PWDATA[mbp_pkg::MBP_PEA_PIPE_STATUS_OUTPUT_ENABLE];
      e_clock_disable <= PWDATA[mbp_pkg::MBP_PEA_E_CLOCK_OUTPUT_DIS];
      low_strobe_enable <= PWDATA[mbp_pkg::MBP_PEA_LOW_STROBE_ENABLE];
      read_write_pin_enable <= PWDATA[mbp_pkg::MBP_PEA_READ_WRITE_PIN_ENABLE];
    end
  end

  // stretch enable set by reset in every user mode
  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      e_clock_stretch_enable <= mbp_pkg::MBP_E_CLOCK_STRETCH_ENABLE_RESET;
    end
    else if (wr_bic)
    begin
      e_clock_stretch_enable <= PWDATA[mbp_pkg::MBP_BIC_E_CLOCK_STRETCH_ENABLE];
    end
  end

  // pin function selects from the latched mode and stored enables
  always_comb
  begin
    next_bus_ab = !single_chip;
    next_sel_no_access_indicator = emulation || (!single_chip && no_access_enable);
    next_sel_pipe = emulation || (!single_chip && pipe_status_output_enable);
    next_sel_e_clock_output = emulation || !e_clock_disable;
    next_sel_low_byte_strobe = emulation || (wide && low_strobe_enable);
    next_sel_rw = emulation || (!single_chip && read_write_pin_enable);
  end

  // registered selects keep pin direction changes glitch-free
  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      bus_ab <= 1'b0;
      sel_no_access_indicator <= 1'b0;
      sel_pipe <= 1'b0;
      sel_e_clock_output <= 1'b0;
      sel_low_byte_strobe <= 1'b0;
      sel_rw <= 1'b0;
    end
    else
    begin
      bus_ab <= next_bus_ab && mode_taken;
      sel_no_access_indicator <= next_sel_no_access_indicator && mode_taken;
      sel_pipe <= next_sel_pipe && mode_taken;
      sel_e_clock_output <= next_sel_e_clock_output && mode_taken;
      sel_low_byte_strobe <= next_sel_low_byte_strobe && mode_taken;
      sel_rw <= next_sel_rw && mode_taken;
    end
  end

  // address or data word, then lane placement by bus width
  always_comb
  begin
    bus_word = CORE_DATA_PHASE ? CORE_WDATA : CORE_ADDR;
    next_a_out = bus_word[15:8];
    next_b_out = bus_word[7:0];
    if (narrow && CORE_DATA_PHASE && !CORE_MAPPED_INTERNAL
      && !(emulation && internal_visibility_enable && !CORE_ACCESS_EXT))
    begin
      // byte-wide external data rides on port a, one byte per cycle
      next_a_out = CORE_HIGH_BYTE ? CORE_WDATA[15:8] : CORE_WDATA[7:0];
      next_b_out = CORE_ADDR[7:0];
    end
  end

  // e clock level; stretched form when stretch enabled
  assign e_clock_level = e_clock_stretch_enable ? e_clock_stretched_s : e_clock_in_s;

  // port e pins: alternates override general purpose only where selected
  always_comb
  begin
    next_e_out = GPIO_E_OUT;
    next_e_oe = GPIO_E_DIR & 8'hfc;
    next_e_pull = ~GPIO_E_DIR;
    next_e_pull[1:0] = 2'h3;
    if (sel_no_access_indicator)
    begin
      next_e_out[mbp_pkg::MBP_PE_NO_ACCESS_INDICATOR] = NO_ACCESS_INDICATOR;
      next_e_oe[mbp_pkg::MBP_PE_NO_ACCESS_INDICATOR] = 1'b1;
      next_e_pull[mbp_pkg::MBP_PE_NO_ACCESS_INDICATOR] = 1'b0;
    end
    if (sel_pipe)
    begin
      next_e_out[mbp_pkg::MBP_PE_PIPE_HI] = PIPE_STATUS_HIGH;
      next_e_out[mbp_pkg::MBP_PE_PIPE_LO] = PIPE_STATUS_LOW;
      next_e_oe[mbp_pkg::MBP_PE_PIPE_HI] = 1'b1;
      next_e_oe[mbp_pkg::MBP_PE_PIPE_LO] = 1'b1;
      next_e_pull[mbp_pkg::MBP_PE_PIPE_HI] = 1'b0;
      next_e_pull[mbp_pkg::MBP_PE_PIPE_LO] = 1'b0;
    end
    if (sel_e_clock_output)
    begin
      next_e_out[mbp_pkg::MBP_PE_E_CLOCK_OUTPUT] = e_clock_level;
      next_e_oe[mbp_pkg::MBP_PE_E_CLOCK_OUTPUT] = 1'b1;
      next_e_pull[mbp_pkg::MBP_PE_E_CLOCK_OUTPUT] = 1'b0;
    end
    if (sel_low_byte_strobe)
    begin
      next_e_out[mbp_pkg::MBP_PE_LOW_BYTE_STROBE] = LOW_BYTE_STROBE_IN;
      next_e_oe[mbp_pkg::MBP_PE_LOW_BYTE_STROBE] = 1'b1;
      next_e_pull[mbp_pkg::MBP_PE_LOW_BYTE_STROBE] = 1'b0;
    end
    if (sel_rw)
    begin
      next_e_out[mbp_pkg::MBP_PE_RW] = !CORE_BUS_WRITE;
      next_e_oe[mbp_pkg::MBP_PE_RW] = 1'b1;
      next_e_pull[mbp_pkg::MBP_PE_RW] = 1'b0;
    end
  end

  // pin outputs from flip-flops; ports a and b reset to undriven inputs without pulls
  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      PORT_A_OUT <= 8'h00;
      PORT_A_OE <= 8'h00;
      PORT_A_PULL <= 8'h00;
      PORT_B_OUT <= 8'h00;
      PORT_B_OE <= 8'h00;
      PORT_B_PULL <= 8'h00;
      PORT_E_OUT <= 8'h00;
      PORT_E_OE <= 8'h00;
      PORT_E_PULL <= 8'h00;
    end
    else
    begin
      PORT_A_OUT <= bus_ab ? next_a_out : GPIO_A_OUT;
      PORT_A_OE <= bus_ab ? {8{CORE_ACCESS_EXT || !CORE_DATA_PHASE || CORE_BUS_WRITE}}
        : GPIO_A_DIR;
      PORT_A_PULL <= 8'h00;
      PORT_B_OUT <= bus_ab ? next_b_out : GPIO_B_OUT;
      PORT_B_OE <= bus_ab ? 8'hff : GPIO_B_DIR;
      PORT_B_PULL <= 8'h00;
      PORT_E_OUT <= next_e_out;
      PORT_E_OE <= next_e_oe;
      PORT_E_PULL <= mode_taken ? next_e_pull : 8'hff;
    end
  end

  // status and read data
  assign pea_value = {no_access_enable, 1'b0, pipe_status_output_enable, e_clock_disable,
    low_strobe_enable, read_write_pin_enable, 2'h0};
  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      PRDATA <= 32'h0;
      MODE <= 3'h4;
      BUS_EXPANDED <= 1'b0;
    end
    else
    begin
      MODE <= mode;
      BUS_EXPANDED <= bus_ab;
      if (PSEL && !PENABLE && !PWRITE)
      begin
        unique case (PADDR)
          mbp_pkg::MBP_OFF_MODE: PRDATA <= {24'h0, mode, 1'b0, internal_visibility_enable, 3'h0};
          mbp_pkg::MBP_OFF_PORT_E_ASSIGN: PRDATA <= {24'h0, pea_value};
          mbp_pkg::MBP_OFF_BUS_CTRL: PRDATA <= {31'h0, e_clock_stretch_enable};
          mbp_pkg::MBP_OFF_PIN_STATUS: PRDATA <= {8'h0, port_a_s, port_b_s, port_e_s};
          default: PRDATA <= 32'h0;
        endcase
      end
    end
  end

  // checks
  single_alt_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
    single_chip |-> ##1 !sel_pipe && !sel_low_byte_strobe && !sel_rw)
    else $error("alternate function selected in single chip");
  narrow_strobe_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
    normal_narrow |-> ##1 !sel_low_byte_strobe)
    else $error("strobe selected in normal narrow");
  e_clock_output_sel_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (mode_taken && !e_clock_disable) |-> ##1 sel_e_clock_output ##1 PORT_E_OE[4])
    else $error("e clock pin not driven");
  emu_ctrl_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (mode_taken && emulation) |-> ##2 (PORT_E_OE[7:2] == 6'h3f))
    else $error("emulation control pins not driven");
  pea_once_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (normal_narrow && pea_written) |=> $stable(pea_value))
    else $error("second assignment write accepted");
  mode_once_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (mode_written && mode_taken) |=> $stable(mode))
    else $error("mode changed after single write");
  narrow_vis_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
    normal_narrow |=> !internal_visibility_enable)
    else $error("visibility on in normal narrow");
  single_bus_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
    single_chip |=> !bus_ab && (PORT_A_PULL == 8'h00))
    else $error("bus active in single chip");
  rw_pin_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (sel_rw) |=> (PORT_E_OUT[2] == !$past(CORE_BUS_WRITE)) && PORT_E_OE[2])
    else $error("rw pin wrong");
endmodule : mbp_top

// file: hdl/mbp_pkg.sv
// package of constants and types for the mode dependent bus port configuration block
package mbp_pkg;
  // operating modes from the three mode select pins
  typedef enum logic [2:0]
  {
    MBP_SPECIAL_SINGLE = 3'h0,
    MBP_EMU_NARROW = 3'h1,
    MBP_SPECIAL_TEST = 3'h2,
    MBP_EMU_WIDE = 3'h3,
    MBP_NORM_SINGLE = 3'h4,
    MBP_NORM_NARROW = 3'h5,
    MBP_PERIPHERAL = 3'h6,
    MBP_NORM_WIDE = 3'h7
  } mbp_mode_t;
  // apb register byte offsets
  localparam logic [11:0] MBP_OFF_MODE = 12'h000;
  localparam logic [11:0] MBP_OFF_PORT_E_ASSIGN = 12'h004;
  localparam logic [11:0] MBP_OFF_BUS_CTRL = 12'h008;
  localparam logic [11:0] MBP_OFF_PIN_STATUS = 12'h00c;
  // mode register fields
  localparam int MBP_MODE_LSB = 5;
  localparam int MBP_MODE_INTERNAL_VISIBILITY_ENABLE = 3;
  // port e assignment register fields
  localparam int MBP_PEA_NO_ACCESS_INDICATOR = 7;
  localparam int MBP_PEA_PIPE_STATUS_OUTPUT_ENABLE = 5;
  localparam int MBP_PEA_E_CLOCK_OUTPUT_DIS = 4;
  localparam int MBP_PEA_LOW_STROBE_ENABLE = 3;
  localparam int MBP_PEA_READ_WRITE_PIN_ENABLE = 2;
  // bus interface control register field
  localparam int MBP_BIC_E_CLOCK_STRETCH_ENABLE = 0;
  // reset values
  localparam logic [7:0] MBP_PEA_RESET = 8'h00;
  localparam logic MBP_E_CLOCK_STRETCH_ENABLE_RESET = 1'b1;
  // port e pin positions
  localparam int MBP_PE_NO_ACCESS_INDICATOR = 7;
  localparam int MBP_PE_PIPE_HI = 6;
  localparam int MBP_PE_PIPE_LO = 5;
  localparam int MBP_PE_E_CLOCK_OUTPUT = 4;
  localparam int MBP_PE_LOW_BYTE_STROBE = 3;
  localparam int MBP_PE_RW = 2;
endpackage : mbp_pkg

// file: hdl/mbp_sync.sv
// two flip-flop synchroniser for a bus of WIDTH pin inputs
`timescale 1ns/100ps
module mbp_sync
#(
  parameter int WIDTH = 1
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // asynchronous in, synchronous out
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] stage1;

  // first stage is read only by the second stage
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stage1 <= '0;
      q <= '0;
    end
    else
    begin
      stage1 <= d;
      q <= stage1;
    end
  end
endmodule : mbp_sync

// file: hdl/mbp_apb.sv
// apb slave front end: decodes a one-cycle access into read and write strobes
`timescale 1ns/100ps
module mbp_apb
(
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  output logic pready,
  output logic pslverr,
  // decoded strobes
  output logic wr_mode,
  output logic wr_pea,
  output logic wr_bic,
  output logic rd_any
);
  logic access;
  logic mapped;

  // zero wait state; unmapped addresses answer with an error
  assign access = psel && penable;
  assign mapped = (paddr == mbp_pkg::MBP_OFF_MODE) || (paddr == mbp_pkg::MBP_OFF_PORT_E_ASSIGN)
    || (paddr == mbp_pkg::MBP_OFF_BUS_CTRL) || (paddr == mbp_pkg::MBP_OFF_PIN_STATUS);
  assign pready = 1'b1;
  assign pslverr = access && !mapped;
  assign wr_mode = access && pwrite && (paddr == mbp_pkg::MBP_OFF_MODE);
  assign wr_pea = access && pwrite && (paddr == mbp_pkg::MBP_OFF_PORT_E_ASSIGN);
  assign wr_bic = access && pwrite && (paddr == mbp_pkg::MBP_OFF_BUS_CTRL);
  assign rd_any = access && !pwrite;
endmodule : mbp_apb

// file: tb/mbp_ext_side.sv
// far-side model: external memory bus pins as seen from outside the ports
`timescale 1ns/100ps
module mbp_ext_side
(
  // clock
  input wire logic clk,
  // pins driven by the block
  input wire logic [23:0] pin_out,
  input wire logic [23:0] pin_oe,
  input wire logic [23:0] pin_pull,
  // resolved pin levels
  output logic [23:0] pin_in
);
  logic [23:0] float_pat;
  // a released line floats: toggle it each cycle so a stale value never reads as a match
  initial float_pat = 24'h5a5a5a;
  always @(posedge clk)
  begin
    float_pat <= ~float_pat;
  end
  // the block wins where it drives, a pull sets the idle level, otherwise the wire floats
  always_comb
  begin
    for (int i = 0; i < 24; i++)
    begin
      pin_in[i] = pin_oe[i] ? pin_out[i] : (pin_pull[i] ? 1'b1 : float_pat[i]);
    end
  end
endmodule : mbp_ext_side

// file: tb/mbp_top_tb_top.sv
// self-checking bench for the mode dependent bus port configuration block
`timescale 1ns/100ps
module mbp_top_tb_top;
  logic CLOCK, RST_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, BUS_EXPANDED;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA, rd;
  logic [2:0] MODE, mpins;
  logic [15:0] CORE_ADDR, CORE_WDATA;
  logic CORE_BUS_WRITE, CORE_ACCESS_EXT, CORE_MAPPED_INTERNAL, CORE_HIGH_BYTE, CORE_DATA_PHASE;
  logic LOW_BYTE_STROBE_IN, PIPE_STATUS_HIGH, PIPE_STATUS_LOW, NO_ACCESS_INDICATOR;
  logic E_CLOCK_IN, E_CLOCK_STRETCHED, err;
  logic [7:0] GPIO_A_OUT, GPIO_A_DIR, GPIO_B_OUT, GPIO_B_DIR, GPIO_E_OUT, GPIO_E_DIR;
  logic [7:0] PORT_A_OUT, PORT_A_OE, PORT_A_PULL, PORT_B_OUT, PORT_B_OE, PORT_B_PULL;
  logic [7:0] PORT_E_OUT, PORT_E_OE, PORT_E_PULL;
  logic [23:0] pin_in;
  int mismatches, cmp_count, cycles;

  // clock and the core's E clock, the latter unrelated in phase
  initial
  begin
    CLOCK = 0;
    forever #5 CLOCK = ~CLOCK;
  end
  initial
  begin
    E_CLOCK_IN = 0;
    #3.3;
    forever #62.5 E_CLOCK_IN = ~E_CLOCK_IN;
  end
  assign E_CLOCK_STRETCHED = E_CLOCK_IN;

  mbp_top i_mbp_top (.CLOCK(CLOCK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .MODE_SELECT_PIN_C(mpins[2]), .MODE_SELECT_PIN_B(mpins[1]),
    .MODE_SELECT_PIN_A(mpins[0]), .CORE_ADDR(CORE_ADDR), .CORE_WDATA(CORE_WDATA),
    .CORE_BUS_WRITE(CORE_BUS_WRITE), .CORE_ACCESS_EXT(CORE_ACCESS_EXT),
    .CORE_MAPPED_INTERNAL(CORE_MAPPED_INTERNAL), .CORE_HIGH_BYTE(CORE_HIGH_BYTE),
    .CORE_DATA_PHASE(CORE_DATA_PHASE), .LOW_BYTE_STROBE_IN(LOW_BYTE_STROBE_IN),
    .PIPE_STATUS_HIGH(PIPE_STATUS_HIGH), .PIPE_STATUS_LOW(PIPE_STATUS_LOW),
    .NO_ACCESS_INDICATOR(NO_ACCESS_INDICATOR), .E_CLOCK_IN(E_CLOCK_IN),
    .E_CLOCK_STRETCHED(E_CLOCK_STRETCHED), .GPIO_A_OUT(GPIO_A_OUT), .GPIO_A_DIR(GPIO_A_DIR),
    .GPIO_B_OUT(GPIO_B_OUT), .GPIO_B_DIR(GPIO_B_DIR), .GPIO_E_OUT(GPIO_E_OUT),
    .GPIO_E_DIR(GPIO_E_DIR), .PORT_A_IN(pin_in[23:16]), .PORT_A_OUT(PORT_A_OUT),
    .PORT_A_OE(PORT_A_OE), .PORT_A_PULL(PORT_A_PULL), .PORT_B_IN(pin_in[15:8]),
    .PORT_B_OUT(PORT_B_OUT), .PORT_B_OE(PORT_B_OE), .PORT_B_PULL(PORT_B_PULL),
    .PORT_E_IN(pin_in[7:0]), .PORT_E_OUT(PORT_E_OUT), .PORT_E_OE(PORT_E_OE),
    .PORT_E_PULL(PORT_E_PULL), .MODE(MODE), .BUS_EXPANDED(BUS_EXPANDED));

  mbp_ext_side i_mbp_ext_side (.clk(CLOCK), .pin_out({PORT_A_OUT, PORT_B_OUT, PORT_E_OUT}),
    .pin_oe({PORT_A_OE, PORT_B_OE, PORT_E_OE}),
    .pin_pull({PORT_A_PULL, PORT_B_PULL, PORT_E_PULL}), .pin_in(pin_in));

  // compare and count; a four-state mismatch is never hidden
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // one apb transfer, entered just after a rising edge; waits for pready, never a fixed count
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    do
    begin
      @(posedge CLOCK);
    end while (PREADY !== 1'b1);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    // one idle edge so a following call never reassigns psel in this time step
    @(posedge CLOCK);
  endtask : apb

  // reset with the mode pins held well before release, then let the mode latch settle
  task automatic do_reset(input logic [2:0] m);
    mpins <= m;
    RST_N <= 1'b0;
    repeat (8) @(posedge CLOCK);
    RST_N <= 1'b1;
    // mode latches at the third edge, selects follow one edge later and pins two edges later
    repeat (6) @(posedge CLOCK);
  endtask : do_reset

  task automatic t_single;
    do_reset(3'h4);
    chk({29'h0, MODE, BUS_EXPANDED}, 32'h8);
    chk({PORT_A_PULL, PORT_B_PULL, PORT_A_OE, PORT_B_OE}, 32'h0);
    chk(PORT_E_PULL & 8'hef, 8'hef);
    chk(PORT_E_OE[4], 1'b1);
    apb(1'b0, mbp_pkg::MBP_OFF_PORT_E_ASSIGN, 32'h0);
    chk(rd[7:0] & 8'h2c, 8'h00);
    apb(1'b0, mbp_pkg::MBP_OFF_BUS_CTRL, 32'h0);
    chk(rd[0], 1'b1);
    apb(1'b0, 12'h010, 32'h0);
    chk(err, 1'b1);
    apb(1'b1, mbp_pkg::MBP_OFF_PORT_E_ASSIGN, 32'h2c);
    repeat (3) @(posedge CLOCK);
    chk(PORT_E_OE & 8'h6c, 8'h00);
    apb(1'b1, mbp_pkg::MBP_OFF_PORT_E_ASSIGN, 32'h10);
    repeat (3) @(posedge CLOCK);
    chk(PORT_E_OE[4], 1'b0);
    apb(1'b1, mbp_pkg::MBP_OFF_MODE, 32'he0);
    apb(1'b1, mbp_pkg::MBP_OFF_MODE, 32'ha0);
    repeat (3) @(posedge CLOCK);
    chk({29'h0, MODE, BUS_EXPANDED}, 32'hf);
    $display("test single chip done");
  endtask : t_single

  task automatic t_wide;
    do_reset(3'h7);
    chk({PORT_E_OE[4], PORT_E_OE[3], PORT_E_PULL[3], BUS_EXPANDED}, 4'hb);
    apb(1'b1, mbp_pkg::MBP_OFF_PORT_E_ASSIGN, 32'h2c);
    repeat (3) @(posedge CLOCK);
    chk(PORT_E_OE & 8'h6c, 8'h6c);
    chk(PORT_E_OUT[2], 1'b0);
    $display("test expanded wide done");
  endtask : t_wide

  task automatic t_narrow;
    do_reset(3'h5);
    apb(1'b1, mbp_pkg::MBP_OFF_PORT_E_ASSIGN, 32'h08);
    apb(1'b1, mbp_pkg::MBP_OFF_PORT_E_ASSIGN, 32'h04);
    apb(1'b0, mbp_pkg::MBP_OFF_PORT_E_ASSIGN, 32'h0);
    chk(rd[7:0] & 8'h2c, 8'h08);
    repeat (3) @(posedge CLOCK);
    chk({PORT_E_OE[3], PORT_E_OE[2], PORT_E_PULL[2]}, 3'h1);
    chk({29'h0, MODE}, 32'h5);
    $display("test expanded narrow done");
  endtask : t_narrow

  task automatic t_emul;
    do_reset(3'h3);
    apb(1'b1, mbp_pkg::MBP_OFF_PORT_E_ASSIGN, 32'h0);
    repeat (3) @(posedge CLOCK);
    chk(PORT_E_OE & 8'hfc, 8'hfc);
    do_reset(3'h1);
    chk({29'h0, MODE}, 32'h1);
    CORE_ACCESS_EXT <= 1'b1;
    CORE_DATA_PHASE <= 1'b1;
    CORE_HIGH_BYTE <= 1'b1;
    repeat (3) @(posedge CLOCK);
    chk({PORT_A_OUT, PORT_B_OUT}, 16'h5a01);
    CORE_MAPPED_INTERNAL <= 1'b1;
    repeat (3) @(posedge CLOCK);
    chk({PORT_A_OUT, PORT_B_OUT}, 16'h5a3c);
    $display("test emulation done");
  endtask : t_emul

  // single place where the run ends
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : final_report

  // hang guard: the whole sequence needs well under a thousand cycles
  always @(posedge CLOCK)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      mismatches++;
      final_report();
    end
  end

  // main sequence; the core stays on a write so the rw pin reads low
  initial
  begin
    {mismatches, cmp_count, cycles} = '0;
    {RST_N, PSEL, PENABLE, PWRITE, PADDR, PWDATA, mpins} = '0;
    CORE_ADDR = 16'h8001;
    CORE_WDATA = 16'h5a3c;
    {CORE_BUS_WRITE, CORE_ACCESS_EXT, CORE_MAPPED_INTERNAL} = 3'h4;
    {CORE_HIGH_BYTE, CORE_DATA_PHASE, LOW_BYTE_STROBE_IN} = 3'h0;
    {PIPE_STATUS_HIGH, PIPE_STATUS_LOW, NO_ACCESS_INDICATOR} = 3'h5;
    {GPIO_A_OUT, GPIO_A_DIR, GPIO_B_OUT, GPIO_B_DIR, GPIO_E_OUT, GPIO_E_DIR} = '0;
    @(posedge CLOCK);
    t_single();
    t_wide();
    t_narrow();
    t_emul();
    final_report();
  end
endmodule : mbp_top_tb_top
